/* File: rtl/amdec_core.v */
// Notes on behaviour
// - Bit set/clear: bit from opcode, byte address from next byte.
// - Bit test-branch: three bytes, sign-extended offset added when true.
// - Test-branch target spans -126 to +129 from opcode address.
// - Test-branch copies tested bit into carry, taken or not.
// - Indirect: bit 4 picks X or Y pointer, one byte long.
// - Inherent: one byte, no operand fetch, opcode decides all.
// - Move-immediate: address byte then constant byte, constant stored.
// - Move-immediate leaves accumulator and zero/carry flags untouched.
// - Short branch: 32-opcode blocks, target is PC plus low five bits.
// - False branch condition falls through to next instruction.
// - Decode 42 operations across nine modes in five classes.
// - Read-modify-write reads, alters, writes back same location.
// - Register/memory ops other than increment and decrement use accumulator; jump and call take none.
// - Wait and stop decode only on the low-power variant.
// - Accumulator is data location 0xFF, reached like any byte.
// - Call and interrupt push PC on four-level stack; return pops.
`timescale 1ns/1ns
`include "amdec_defs.vh"
module amdec_core #(
  parameter LOW_POWER = 1,
  parameter [11:0] RST_VEC = `AMDEC_RST_VEC,
  parameter [11:0] IRQ_VEC = `AMDEC_IRQ_VEC,
  parameter DEPTH = `AMDEC_STACK_DEPTH
) (
  input wire i_clock,
  input wire i_nrst,
  input wire i_irq,
  output wire [11:0] o_pm_addr,
  input wire [7:0] i_pm_data,
  output wire [7:0] o_dm_addr,
  output wire o_dm_wr,
  output wire [7:0] o_dm_wdata,
  input wire [7:0] i_dm_rdata,
  input wire i_dm_ro,
  output wire o_carry,
  output wire o_zero,
  output wire o_halted
);
  localparam [2:0] S_FETCH = 3'h0;
  localparam [2:0] S_PTR = 3'h1;
  localparam [2:0] S_OPND = 3'h2;
  localparam [2:0] S_ACC = 3'h3;
  localparam [2:0] S_HALT = 3'h4;

  reg [2:0] state_q;
  reg [11:0] pc_q;
  reg [1:0] idx_q;
  reg [7:0] opc_q;
  reg [7:0] b2_q;
  reg [7:0] rel_q;
  reg [7:0] ea_q;
  reg [7:0] opnd_q;
  reg [2:0] aop_q;
  reg [7:0] dm_addr_q;
  reg [7:0] dm_wdata_q;
  reg dm_wr_q;
  reg carry_q;
  reg zero_q;
  reg isr_q;

  wire [11:0] stk_top;

  // Instruction length from the first byte
  function [1:0] op_len;
    input [7:0] o;
    begin
      casez (o)
        8'b0???_????: op_len = `AMDEC_LEN1;
        8'b100?_????: op_len = `AMDEC_LEN2;
        `AMDEC_MOVI: op_len = `AMDEC_LEN3;
        8'b101?_????: op_len = `AMDEC_LEN1;
        8'b1100_????: op_len = `AMDEC_LEN3;
        8'b1101_????: op_len = `AMDEC_LEN2;
        default: op_len = o[3] ? `AMDEC_LEN2 : `AMDEC_LEN1;
      endcase
    end
  endfunction

  // Program memory reads asynchronously from the registered PC
  wire [7:0] op = (idx_q == 2'h0) ? i_pm_data : opc_q;
  wire [1:0] len = op_len(op);
  wire last = (idx_q == len - 2'h1);
  wire [7:0] b2 = (idx_q == 2'h1) ? i_pm_data : b2_q;
  wire [11:0] pc_inc = pc_q + 12'h001;
  wire fetching = (state_q == S_FETCH);
  wire irq_take = fetching && (idx_q == 2'h0) && i_irq && !isr_q;
  wire [7:0] ptr_addr = `AMDEC_X_ADDR | {7'h00, op[4]};
  wire [7:0] short_ea = {`AMDEC_SHORT_BASE, op[1:0]};
  wire [11:0] short_tgt = pc_inc + {{7{op[4]}}, op[4:0]};
  wire [11:0] test_tgt = pc_q - 12'h001 + {{4{rel_q[7]}}, rel_q};
  wire tested = i_dm_rdata[opc_q[2:0]];
  wire [7:0] bit_mask = 8'h01 << opc_q[2:0];

  // Short branch condition on zero and carry
  reg cond_true;
  always @* begin
    case (op[6:5])
      `AMDEC_C_NE: cond_true = !zero_q;
      `AMDEC_C_EQ: cond_true = zero_q;
      `AMDEC_C_CC: cond_true = !carry_q;
      default: cond_true = carry_q;
    endcase
  end

  // Stack control: call at its last byte, interrupt before fetch
  wire is_call = fetching && last && !irq_take && (op[7:4] == 4'h8);
  wire is_ret = fetching && last && !irq_take &&
    ((op == `AMDEC_RETS) || (op == `AMDEC_RETI));
  wire stk_push = irq_take || is_call;
  wire [11:0] push_val = irq_take ? pc_q : pc_inc;

  amdec_stack #(
    .WIDTH(`AMDEC_PC_W),
    .DEPTH(DEPTH)
  ) u_stack (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_push(stk_push),
    .i_pop(is_ret),
    .i_data(push_val),
    .o_top(stk_top)
  );

  // Accumulator ALU; acc arrives on the data bus in S_ACC
  reg [8:0] sum;
  reg [7:0] res;
  reg c_new;
  reg c_upd;
  reg acc_wr;
  always @* begin
    sum = 9'h000;
    res = i_dm_rdata;
    c_new = carry_q;
    c_upd = 1'b0;
    acc_wr = 1'b1;
    if (opc_q == `AMDEC_COMA) begin
      res = ~i_dm_rdata;
      c_new = 1'b1;
      c_upd = 1'b1;
    end else if (opc_q == `AMDEC_ROLA) begin
      res = {i_dm_rdata[6:0], carry_q};
      c_new = i_dm_rdata[7];
      c_upd = 1'b1;
    end else begin
      case (aop_q)
        `AMDEC_OP_LD: res = opnd_q;
        `AMDEC_OP_ST: acc_wr = 1'b0;
        `AMDEC_OP_ADD: begin
          sum = {1'b0, i_dm_rdata} + {1'b0, opnd_q};
          res = sum[7:0];
          c_new = sum[8];
          c_upd = 1'b1;
        end
        `AMDEC_OP_AND: res = i_dm_rdata & opnd_q;
        default: begin
          // Subtract and compare; compare keeps the accumulator
          sum = {1'b0, i_dm_rdata} - {1'b0, opnd_q};
          res = sum[7:0];
          c_new = sum[8];
          c_upd = 1'b1;
          acc_wr = (aop_q != `AMDEC_OP_CMP);
        end
      endcase
    end
  end

  // Sequencer: fetch bytes, then walk the data-space accesses
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= S_FETCH;
      pc_q <= RST_VEC;
      idx_q <= 2'h0;
      opc_q <= 8'h00;
      b2_q <= 8'h00;
      rel_q <= 8'h00;
      ea_q <= 8'h00;
      opnd_q <= 8'h00;
      aop_q <= `AMDEC_OP_LD;
      dm_addr_q <= 8'h00;
      dm_wdata_q <= 8'h00;
      dm_wr_q <= 1'b0;
      carry_q <= 1'b0;
      zero_q <= 1'b0;
      isr_q <= 1'b0;
    end else begin
      dm_wr_q <= 1'b0;
      case (state_q)
        S_FETCH: begin
          if (irq_take) begin
            pc_q <= IRQ_VEC;
            isr_q <= 1'b1;
          end else begin
            pc_q <= pc_inc;
            if (idx_q == 2'h0) begin
              opc_q <= i_pm_data;
            end
            if (idx_q == 2'h1) begin
              b2_q <= i_pm_data;
            end
            if (!last) begin
              idx_q <= idx_q + 2'h1;
            end else begin
              idx_q <= 2'h0;
              // Class decode of the whole opcode space
              casez (op)
                8'b0???_????: begin
                  if (cond_true) begin
                    pc_q <= short_tgt;
                  end
                end
                8'b100?_????: begin
                  pc_q <= {op[3:0], b2};
                end
                `AMDEC_MOVI: begin
                  // No acc read, no flag update on this path
                  dm_addr_q <= b2_q;
                  dm_wdata_q <= i_pm_data;
                  dm_wr_q <= 1'b1;
                end
                `AMDEC_RETS: pc_q <= stk_top;
                `AMDEC_RETI: begin
                  pc_q <= stk_top;
                  isr_q <= 1'b0;
                end
                `AMDEC_COMA, `AMDEC_ROLA: begin
                  dm_addr_q <= `AMDEC_ACC_ADDR;
                  state_q <= S_ACC;
                end
                `AMDEC_STOPI, `AMDEC_WAITI: begin
                  // Other variants run these as no-ops
                  if (LOW_POWER != 0) begin
                    state_q <= S_HALT;
                  end
                end
                8'b101?_1???: begin
                  ea_q <= short_ea;
                  // Bits 4 and 2 pick increment, load, decrement, store
                  aop_q <= {~op[2], ~op[2], op[4]};
                  if (op[4] && op[2]) begin
                    dm_addr_q <= `AMDEC_ACC_ADDR;
                    state_q <= S_ACC;
                  end else begin
                    dm_addr_q <= short_ea;
                    state_q <= S_OPND;
                  end
                end
                8'b1100_????: begin
                  ea_q <= b2_q;
                  rel_q <= i_pm_data;
                  dm_addr_q <= b2_q;
                  state_q <= S_OPND;
                end
                8'b1101_????: begin
                  ea_q <= b2;
                  dm_addr_q <= b2;
                  state_q <= S_OPND;
                end
                8'b111?_????: begin
                  aop_q <= op[2:0];
                  if (!op[3]) begin
                    dm_addr_q <= ptr_addr;
                    state_q <= S_PTR;
                  end else if (!op[4]) begin
                    opnd_q <= b2;
                    dm_addr_q <= `AMDEC_ACC_ADDR;
                    state_q <= S_ACC;
                  end else begin
                    ea_q <= b2;
                    if (op[2:0] == `AMDEC_OP_ST) begin
                      dm_addr_q <= `AMDEC_ACC_ADDR;
                      state_q <= S_ACC;
                    end else begin
                      dm_addr_q <= b2;
                      state_q <= S_OPND;
                    end
                  end
                end
                default: ;
              endcase
            end
          end
        end
        S_PTR: begin
          ea_q <= i_dm_rdata;
          if (aop_q == `AMDEC_OP_ST) begin
            dm_addr_q <= `AMDEC_ACC_ADDR;
            state_q <= S_ACC;
          end else begin
            dm_addr_q <= i_dm_rdata;
            state_q <= S_OPND;
          end
        end
        S_OPND: begin
          opnd_q <= i_dm_rdata;
          state_q <= S_FETCH;
          casez (opc_q)
            8'b1101_????: begin
              // Read-only byte: skip the write back
              if (!i_dm_ro) begin
                dm_wr_q <= 1'b1;
                dm_wdata_q <= opc_q[3] ? (i_dm_rdata | bit_mask) :
                  (i_dm_rdata & ~bit_mask);
              end
            end
            8'b1100_????: begin
              carry_q <= tested;
              if (tested == opc_q[3]) begin
                pc_q <= test_tgt;
              end
            end
            default: begin
              if (aop_q == `AMDEC_OP_INC || aop_q == `AMDEC_OP_DEC) begin
                dm_wr_q <= 1'b1;
                dm_wdata_q <= (aop_q == `AMDEC_OP_INC) ?
                  i_dm_rdata + 8'h01 : i_dm_rdata - 8'h01;
                zero_q <= (aop_q == `AMDEC_OP_INC) ?
                  (i_dm_rdata == 8'hff) : (i_dm_rdata == 8'h01);
              end else begin
                dm_addr_q <= `AMDEC_ACC_ADDR;
                state_q <= S_ACC;
              end
            end
          endcase
        end
        S_ACC: begin
          state_q <= S_FETCH;
          zero_q <= (res == 8'h00);
          if (c_upd) begin
            carry_q <= c_new;
          end
          if (opc_q[7:5] == 3'h7 || opc_q[7:5] == 3'h5) begin
            if (!acc_wr && aop_q == `AMDEC_OP_ST &&
                opc_q != `AMDEC_COMA && opc_q != `AMDEC_ROLA) begin
              dm_addr_q <= ea_q;
              dm_wdata_q <= i_dm_rdata;
              dm_wr_q <= 1'b1;
            end else if (acc_wr) begin
              dm_wdata_q <= res;
              dm_wr_q <= 1'b1;
            end
          end
        end
        S_HALT: begin
          // Any interrupt request wakes the core
          if (i_irq) begin
            state_q <= S_FETCH;
          end
        end
        default: state_q <= S_FETCH;
      endcase
    end
  end

  assign o_pm_addr = pc_q;
  assign o_dm_addr = dm_addr_q;
  assign o_dm_wr = dm_wr_q;
  assign o_dm_wdata = dm_wdata_q;
  assign o_carry = carry_q;
  assign o_zero = zero_q;
  assign o_halted = (state_q == S_HALT);
endmodule // amdec_core

/* File: rtl/amdec_defs.vh */
`ifndef AMDEC_DEFS_VH
`define AMDEC_DEFS_VH

// Fixed data-space locations
`define AMDEC_X_ADDR 8'h80
`define AMDEC_ACC_ADDR 8'hff
`define AMDEC_SHORT_BASE 6'h20

// Vectors and stack shape
`define AMDEC_RST_VEC 12'hffe
`define AMDEC_IRQ_VEC 12'hffc
`define AMDEC_PC_W 12
`define AMDEC_STACK_DEPTH 4

// Instruction lengths in bytes
`define AMDEC_LEN1 2'h1
`define AMDEC_LEN2 2'h2
`define AMDEC_LEN3 2'h3

// Register/memory operation field
`define AMDEC_OP_LD 3'h0
`define AMDEC_OP_ST 3'h1
`define AMDEC_OP_ADD 3'h2
`define AMDEC_OP_SUB 3'h3
`define AMDEC_OP_CMP 3'h4
`define AMDEC_OP_AND 3'h5
`define AMDEC_OP_INC 3'h6
`define AMDEC_OP_DEC 3'h7

// Single opcodes
`define AMDEC_MOVI 8'hb0
`define AMDEC_RETI 8'hb2
`define AMDEC_RETS 8'hb3
`define AMDEC_COMA 8'hb4
`define AMDEC_ROLA 8'hb5
`define AMDEC_STOPI 8'hb6
`define AMDEC_WAITI 8'hb7

// Branch conditions, opcode bits 6:5
`define AMDEC_C_NE 2'h0
`define AMDEC_C_EQ 2'h1
`define AMDEC_C_CC 2'h2
`define AMDEC_C_CS 2'h3

`endif

/* File: rtl/amdec_stack.v */
`timescale 1ns/1ns
`include "amdec_defs.vh"
// Shift stack for return addresses; oldest entry falls off the bottom
module amdec_stack #(
  parameter WIDTH = `AMDEC_PC_W,
  parameter DEPTH = `AMDEC_STACK_DEPTH
) (
  input wire i_clock,
  input wire i_nrst,
  input wire i_push,
  input wire i_pop,
  input wire [WIDTH-1:0] i_data,
  output wire [WIDTH-1:0] o_top
);
  reg [WIDTH-1:0] lvl_q [0:DEPTH-1];
  integer k;

  // Push shifts down, pop shifts up, each in one cycle; push wins over pop
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      for (k = 0; k < DEPTH; k = k + 1) begin
        lvl_q[k] <= {WIDTH{1'b0}};
      end
    end else if (i_push) begin
      lvl_q[0] <= i_data;
      for (k = 1; k < DEPTH; k = k + 1) begin
        lvl_q[k] <= lvl_q[k-1];
      end
    end else if (i_pop) begin
      for (k = 0; k < DEPTH - 1; k = k + 1) begin
        lvl_q[k] <= lvl_q[k+1];
      end
    end
  end

  assign o_top = lvl_q[0];
endmodule // amdec_stack

/* File: dv/amdec_checker.sv */
`timescale 1ns/1ns
`include "amdec_defs.vh"
// A fetch shows as the PC stepping by one at the next edge
module amdec_checker (
  input wire i_clock,
  input wire i_nrst,
  input wire [11:0] o_pm_addr,
  input wire [7:0] i_pm_data,
  input wire [7:0] o_dm_addr,
  input wire o_dm_wr,
  input wire [7:0] o_dm_wdata,
  input wire i_dm_ro,
  input wire o_carry,
  input wire o_zero
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  sequence step;
    o_pm_addr == $past(o_pm_addr) + 12'h001;
  endsequence
  sequence movi;
    i_pm_data == `AMDEC_MOVI ##1 step ##1 step;
  endsequence
  // A fetch moves the PC, data-space cycles hold it unless a test-branch is taken; operand bytes in
  // the test programs stay out of the 0x40-0x5f carry-clear branch block for this reason
  sequence moved;
    o_pm_addr != $past(o_pm_addr);
  endsequence
  // Taken: the very next PC is the target from the low five opcode bits
  property bcc_go;
    logic [11:0] t;
    (i_pm_data[7:5] == 3'b010 && !o_carry,
     t = o_pm_addr + 12'h001 + {{7{i_pm_data[4]}}, i_pm_data[4:0]})
    ##1 moved |-> o_pm_addr == t;
  endproperty
  // Not taken: the very next PC is the following byte
  property bcc_fall;
    logic [11:0] n;
    (i_pm_data[7:5] == 3'b010 && o_carry, n = o_pm_addr + 12'h001)
    ##1 moved |-> o_pm_addr == n;
  endproperty
  property ptr_pick;
    logic s;
    (i_pm_data[7:5] == 3'b111 && !i_pm_data[3], s = i_pm_data[4])
    ##1 step |-> ##[0:2] o_dm_addr == {7'h40, s};
  endproperty
  chk_movi_write:
    assert property (movi |=> o_dm_wr && o_dm_addr == $past(i_pm_data, 2)
      && o_dm_wdata == $past(i_pm_data)) else $error("bad move store");
  chk_movi_flags:
    assert property (movi |=> $stable({o_carry, o_zero}))
      else $error("move changed flags");
  chk_ro_quiet:
    assert property (o_dm_wr |-> !i_dm_ro) else $error("read-only store");
  chk_wr_single:
    assert property (o_dm_wr |=> !o_dm_wr) else $error("long store");
  chk_coma_acc:
    assert property (i_pm_data == `AMDEC_COMA ##1 step
      |-> ##[0:6] o_dm_wr && o_dm_addr == `AMDEC_ACC_ADDR)
      else $error("complement missed acc");
  chk_bcc_taken:
    assert property (bcc_go) else $error("branch target wrong");
  chk_bcc_fall:
    assert property (bcc_fall) else $error("branch fall wrong");
  chk_ptr_pick:
    assert property (ptr_pick) else $error("wrong pointer read");
  cover property (movi);
  cover property (o_dm_wr && o_dm_addr == `AMDEC_ACC_ADDR);
  cover property (i_pm_data[7:4] == 4'hc ##1 step);
endmodule // amdec_checker

/* File: dv/amdec_mem_model.sv */
`timescale 1ns/1ns
// Program and data space, both answering in the same cycle
module amdec_mem_model #(
  parameter [7:0] RO_LO = 8'hc0,
  parameter [7:0] RO_HI = 8'hcf
) (
  input wire i_clock,
  input wire [11:0] i_pm_addr,
  output wire [7:0] o_pm_data,
  input wire [7:0] i_dm_addr,
  input wire i_dm_wr,
  input wire [7:0] i_dm_wdata,
  output wire [7:0] o_dm_rdata,
  output wire o_dm_ro
);
  logic [7:0] pmem [0:4095];
  logic [7:0] dmem [0:255];
  logic [7:0] ro_hits;
  assign o_pm_data = pmem[i_pm_addr];
  assign o_dm_rdata = dmem[i_dm_addr];
  assign o_dm_ro = (i_dm_addr >= RO_LO) && (i_dm_addr <= RO_HI);
  // Table area keeps its bytes; stray stores are counted so they show
  always @(posedge i_clock) begin
    if (i_dm_wr && o_dm_ro) begin
      ro_hits <= ro_hits + 8'h01;
    end else if (i_dm_wr) begin
      dmem[i_dm_addr] <= i_dm_wdata;
    end
  end
endmodule // amdec_mem_model

/* File: dv/test_addressing_mode_decoder.sv */
`timescale 1ns/1ns
// Short programs run on the core; data space and flags judged after
module test_addressing_mode_decoder;
  logic i_clock;
  logic i_nrst;
  logic i_irq;
  wire [11:0] pa;
  wire [7:0] pd, da, dw, dr;
  wire wr, ro, c, z, hl;
  int err_count;
  int tests_run;

  amdec_core u_dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_irq(i_irq),
    .o_pm_addr(pa), .i_pm_data(pd), .o_dm_addr(da), .o_dm_wr(wr),
    .o_dm_wdata(dw), .i_dm_rdata(dr), .i_dm_ro(ro), .o_carry(c),
    .o_zero(z), .o_halted(hl));
  amdec_mem_model u_mem (.i_clock(i_clock), .i_pm_addr(pa), .o_pm_data(pd),
    .i_dm_addr(da), .i_dm_wr(wr), .i_dm_wdata(dw), .o_dm_rdata(dr),
    .o_dm_ro(ro));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic put(input logic [11:0] a, input logic [7:0] q[$]);
    foreach (q[i]) u_mem.pmem[a + 12'(i)] = q[i];
  endtask

  // Reset held while memories are cleared; the vector jumps to zero
  task automatic start;
    @(negedge i_clock);
    i_nrst = 1'b0;
    for (int i = 0; i < 4096; i++) u_mem.pmem[i] = 8'h00;
    for (int i = 0; i < 256; i++) u_mem.dmem[i] = 8'h00;
    u_mem.ro_hits = 8'h00;
    put(12'hffe, '{8'h90, 8'h00});
  endtask

  task automatic run;
    repeat (20) @(negedge i_clock);
    i_nrst = 1'b1;
    repeat (300) @(negedge i_clock);
  endtask

  // Complement sets both flags, then two moves must leave them alone
  task automatic t_movi;
    start;
    u_mem.dmem[8'hff] = 8'hff;
    put(12'h000, '{8'hb4, 8'hb0, 8'h10, 8'h3c, 8'hb0, 8'h81, 8'h33,
                   8'h90, 8'h07});
    run;
    check("movi ram", u_mem.dmem[8'h10], 8'h3c);
    check("movi reg", u_mem.dmem[8'h81], 8'h33);
    check("movi acc", u_mem.dmem[8'hff], 8'h00);
    check("movi flags", {6'h00, c, z}, 8'h03);
  endtask

  // Set, clear, and a set aimed at the read-only table
  task automatic t_bits;
    start;
    u_mem.dmem[8'hff] = 8'h0f;
    u_mem.dmem[8'h21] = 8'hff;
    put(12'h000, '{8'hb4, 8'hd9, 8'h20, 8'hdf, 8'h20, 8'hd3, 8'h21,
                   8'hd8, 8'hc5, 8'h90, 8'h09});
    run;
    check("bit set", u_mem.dmem[8'h20], 8'h82);
    check("bit clear", u_mem.dmem[8'h21], 8'hf7);
    check("ro byte", u_mem.dmem[8'hc5], 8'h00);
    check("ro stores", u_mem.ro_hits, 8'h00);
    check("bit flags", {6'h00, c, z}, 8'h02);
  endtask

  // Test-branch: fall, forward limit, backward limit, carry copy
  task automatic t_tbr;
    start;
    u_mem.dmem[8'h22] = 8'h08;
    put(12'h000, '{8'hc3, 8'h22, 8'h7f, 8'hcb, 8'h22, 8'h7f,
                   8'hb0, 8'h30, 8'h3c});
    put(12'h009, '{8'hc3, 8'h22, 8'h7f, 8'hb0, 8'h32, 8'h3c, 8'h90, 8'h0f});
    put(12'h081, '{8'h90, 8'h81, 8'h00, 8'hb0, 8'h31, 8'h3c,
                   8'hc4, 8'h22, 8'h80});
    run;
    check("tbr wrong", u_mem.dmem[8'h30], 8'h00);
    check("tbr far", u_mem.dmem[8'h31], 8'h3c);
    check("tbr back", u_mem.dmem[8'h32], 8'h3c);
    check("tbr carry", {7'h00, c}, 8'h01);
  endtask

  // Pointers, write-back, accumulator at FF and short branches
  task automatic t_mix;
    start;
    u_mem.dmem[8'hff] = 8'h05;
    u_mem.dmem[8'h80] = 8'h25;
    u_mem.dmem[8'h81] = 8'h26;
    u_mem.dmem[8'h25] = 8'h03;
    u_mem.dmem[8'h26] = 8'h10;
    put(12'h000, '{8'he2, 8'h42, 8'hd8, 8'h27, 8'hf6, 8'hfe, 8'h25,
                   8'hfa, 8'hff, 8'hb4, 8'h43, 8'hd8, 8'h28, 8'h90, 8'h0d});
    run;
    check("rmw direct", u_mem.dmem[8'h25], 8'h04);
    check("rmw y ptr", u_mem.dmem[8'h26], 8'h11);
    check("bcc skip", u_mem.dmem[8'h27], 8'h00);
    check("bcc fall", u_mem.dmem[8'h28], 8'h01);
    check("acc", u_mem.dmem[8'hff], 8'hef);
  endtask

  // Call and return, short increment, wait, interrupt entry and return
  task automatic t_call;
    start;
    put(12'h000, '{8'h80, 8'h10, 8'ha8, 8'hb7, 8'hb0, 8'h36, 8'h99,
                   8'hb6});
    put(12'h010, '{8'hb0, 8'h34, 8'ha5, 8'hb3});
    put(12'h020, '{8'hb0, 8'h35, 8'h77, 8'hb2});
    put(12'hffc, '{8'h90, 8'h20});
    run;
    check("call body", u_mem.dmem[8'h34], 8'ha5);
    check("short inc", u_mem.dmem[8'h80], 8'h01);
    check("wait halt", {7'h00, hl}, 8'h01);
    check("wait pc", pa[7:0], 8'h04);
    // Level request: dropped inside the handler so it is not retaken
    i_irq = 1'b1;
    repeat (3) @(negedge i_clock);
    check("irq wake", {7'h00, hl}, 8'h00);
    i_irq = 1'b0;
    repeat (30) @(negedge i_clock);
    check("isr body", u_mem.dmem[8'h35], 8'h77);
    check("reti back", u_mem.dmem[8'h36], 8'h99);
    check("stop halt", {7'h00, hl}, 8'h01);
    check("stop pc", pa[7:0], 8'h08);
  endtask

  initial begin
    err_count = 0;
    tests_run = 0;
    i_irq = 1'b0;
    i_nrst = 1'b0;
    t_movi;
    t_bits;
    t_tbr;
    t_mix;
    t_call;
    wrap_up;
  end

  // Five runs of about 320 cycles; far past that means a hang
  initial begin
    #100000;
    err_count++;
    wrap_up;
  end
endmodule // test_addressing_mode_decoder

bind amdec_core amdec_checker u_chk (.i_clock(i_clock), .i_nrst(i_nrst),
  .o_pm_addr(o_pm_addr), .i_pm_data(i_pm_data), .o_dm_addr(o_dm_addr),
  .o_dm_wr(o_dm_wr), .o_dm_wdata(o_dm_wdata), .i_dm_ro(i_dm_ro),
  .o_carry(o_carry), .o_zero(o_zero));
